// File: rtl/taip_top.sv
// Purpose: temperature alert logic with two-wire register port
// Assumes: acquisitions arrive as a one-cycle done pulse with data on clk_sys
// Notes: scl and sda are sampled by clk_sys; open-drain outputs use enables
// How it works
// RULE1: each finished acquisition is checked against hot, cold and baseline
// RULE2: first reading after wake goes high becomes the baseline
// RULE3: change at or above threshold sets change flag and moves baseline
// RULE4: two-bit field picks change threshold, resets to two degrees
// RULE5: reading at or below cold threshold sets cold flag and interrupt
// RULE6: reading between thresholds sets neither hot nor cold
// RULE7: reading at or above hot threshold sets hot flag and interrupt
// RULE8: change interrupt enable resets off; flag still sets
// RULE9: host starts a measurement by writing 0x80 to configuration
// RULE10: host waits for end of conversion before reading the result
// RULE11: host should mask hot or cold while polling until recovered
// RULE12: two-wire slave up to 400 kbit/s with auto-increment
// RULE13: start and stop are sda edges while scl is high
// RULE14: matching address is acknowledged, next byte is the sub-address
// RULE15: write stores next byte; read returns register as one byte
// RULE16: transaction ends on stop or after the data byte; code ends it only on stop, read nack or address mismatch
// RULE17: address, sub-address and data bytes are acknowledged
// RULE18: register pointer advances after every data byte
// RULE19: readings are signed eight-bit whole degrees
// RULE20: reading a status register clears its flags and the interrupt
// RULE21: enables gate only the interrupt output, never the flags
// RULE22: persisting hot or cold sets its flag again each acquisition
`timescale 1ns/1ps
`default_nettype none
module taip_top
    import taip_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = 7'h2A    // arbitrary default
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic wake_pin,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic conv_done,
    input wire logic [7:0] conv_data,
    output logic conv_start,
    output logic irq_out_n,
    output logic irq_oe
);

    // ==========================================================
    // input synchronisers
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [1:0] wake_s;

    // two stages, then a third for scl and sda edge history; wake has two stages only
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
            wake_s <= 2'h0;
        end else begin
            scl_s <= {scl_s[1:0], scl_in};
            sda_s <= {sda_s[1:0], sda_in};
            wake_s <= {wake_s[0], wake_pin};
        end
    end

    logic scl_rise, scl_fall, bus_start, bus_stop, sda_now, wake_hi;
    // edges seen only after the second stage
    assign scl_rise = scl_s[1] & ~scl_s[2];
    assign scl_fall = ~scl_s[1] & scl_s[2];
    // RULE13 start and stop
    assign bus_start = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
    assign bus_stop = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];
    assign sda_now = sda_s[1];
    assign wake_hi = wake_s[1];

    // ==========================================================
    // two-wire slave
    taip_i2c_t i2c, next_i2c;
    taip_core_t core, next_core;
    logic wr_en, clr_one, clr_two;
    logic [7:0] wr_addr, wr_data, rd_val;

    // register read decode
    always_comb begin
        unique case (i2c.ptr)
            REG_TEMPERATURE_READOUT: rd_val = core.reading;
            REG_IRQ_ENABLE_ONE: rd_val = {5'h00, core.enable_one};
            REG_IRQ_ENABLE_TWO: rd_val = {7'h00, core.enable_two};
            REG_IRQ_STATUS_GROUP_ONE: rd_val = {5'h00, core.status_one};
            REG_IRQ_STATUS_TWO: rd_val = {7'h00, core.status_two};
            REG_THERMISTOR_CONFIG: rd_val = {2'h0, ~core.busy, 3'h0, core.change_field};
            REG_ALARM_THRESHOLDS: rd_val = {core.hot_threshold, core.cold_threshold};
            default: rd_val = 8'h00;
        endcase
    end

    // RULE12 slave next state
    always_comb begin
        next_i2c = i2c;
        wr_en = 1'b0;
        wr_addr = i2c.ptr;
        wr_data = i2c.sh;
        clr_one = 1'b0;
        clr_two = 1'b0;
        if (bus_start) begin
            // RULE13 start restarts framing
            next_i2c.state = ST_ADDR;
            next_i2c.cnt = 4'h0;
            next_i2c.oe = 1'b0;
        end else if (bus_stop) begin
            // RULE16 stop ends transaction
            next_i2c.state = ST_IDLE;
            next_i2c.oe = 1'b0;
        end else begin
            unique case (i2c.state)
                ST_IDLE: begin
                end
                ST_ADDR, ST_SUB, ST_WDATA: begin
                    if (scl_rise) begin
                        next_i2c.sh = {i2c.sh[6:0], sda_now};
                        next_i2c.cnt = i2c.cnt + 4'h1;
                    end else if (scl_fall && i2c.cnt == 4'h8) begin
                        next_i2c.cnt = 4'h0;
                        next_i2c.state = ST_ACK;
                        // RULE17 acknowledge each byte
                        next_i2c.oe = 1'b1;
                        if (i2c.state == ST_ADDR) begin
                            // RULE14 address match
                            if (i2c.sh[7:1] != SLAVE_ADDR) begin
                                next_i2c.state = ST_IDLE;
                                next_i2c.oe = 1'b0;
                            end
                            next_i2c.ack_to = i2c.sh[0] ? ST_RDATA : ST_SUB;
                        end else if (i2c.state == ST_SUB) begin
                            // RULE14 sub-address byte
                            next_i2c.ptr = i2c.sh;
                            next_i2c.ack_to = ST_WDATA;
                        end else begin
                            // RULE15 write byte
                            wr_en = 1'b1;
                            // RULE18 pointer advance
                            next_i2c.ptr = i2c.ptr + 8'h01;
                            next_i2c.ack_to = ST_WDATA;
                        end
                    end
                end
                ST_ACK, ST_RACK: begin
                    if (i2c.state == ST_RACK && scl_rise) begin
                        next_i2c.mack = ~sda_now;
                    end else if (scl_fall) begin
                        next_i2c.oe = 1'b0;
                        next_i2c.state = (i2c.state == ST_RACK) ? (i2c.mack ? ST_RDATA : ST_IDLE) : i2c.ack_to;
                        if (next_i2c.state == ST_RDATA) begin
                            // RULE15 load one byte, first bit out
                            next_i2c.tx = rd_val;
                            next_i2c.oe = ~rd_val[7];
                            next_i2c.cnt = 4'h0;
                            // RULE18 pointer advance
                            next_i2c.ptr = i2c.ptr + 8'h01;
                            // RULE20 read clears status
                            clr_one = (i2c.ptr == REG_IRQ_STATUS_GROUP_ONE);
                            clr_two = (i2c.ptr == REG_IRQ_STATUS_TWO);
                        end
                    end
                end
                ST_RDATA: begin
                    if (scl_rise) begin
                        next_i2c.cnt = i2c.cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (i2c.cnt == 4'h8) begin
                            next_i2c.oe = 1'b0;
                            next_i2c.state = ST_RACK;
                        end else begin
                            next_i2c.tx = {i2c.tx[6:0], 1'b0};
                            next_i2c.oe = ~i2c.tx[6];
                        end
                    end
                end
            endcase
        end
    end

    // slave registers
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            i2c <= '{state: ST_IDLE, ack_to: ST_SUB, cnt: 4'h0, sh: 8'h00, tx: 8'h00,
                     ptr: 8'h00, mack: 1'b0, oe: 1'b0};
        end else begin
            i2c <= next_i2c;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe = i2c.oe;

    // ==========================================================
    // alert core
    logic signed [7:0] rd_signed;
    logic is_cold, is_hot, big_change;
    logic [2:0] set_one;
    logic [7:0] change_thr;

    // RULE19 signed compares
    assign rd_signed = $signed(conv_data);
    // RULE4 change threshold select
    assign change_thr = CHANGE_BASE_DEG + {6'h00, core.change_field};
    // RULE5 cold compare
    assign is_cold = rd_signed <= taip_cold_deg(core.cold_threshold);
    // RULE7 hot compare
    assign is_hot = rd_signed >= taip_hot_deg(core.hot_threshold);
    // RULE3 change compare
    assign big_change = taip_abs_diff(conv_data, core.baseline) >= {1'b0, change_thr};

    // core next state
    always_comb begin
        next_core = core;
        next_core.start = 1'b0;
        set_one = 3'h0;
        if (conv_done) begin
            // RULE1 compare every acquisition
            next_core.reading = conv_data;
            next_core.busy = 1'b0;
            // RULE6 RULE22 only crossings set, every time
            set_one[FLD_COLD] = is_cold;
            set_one[FLD_HOT] = is_hot;
            if (!core.base_valid) begin
                // RULE2 first reading is baseline
                next_core.baseline = conv_data;
                next_core.base_valid = wake_hi;
            end else if (big_change) begin
                // RULE3 flag and new baseline
                set_one[FLD_CHANGE] = 1'b1;
                next_core.baseline = conv_data;
            end
        end
        // RULE20 RULE21 clear on read, set wins
        next_core.status_one = (clr_one ? 3'h0 : core.status_one) | set_one;
        next_core.status_two = (clr_two ? 1'b0 : core.status_two) | conv_done;
        if (wr_en) begin
            unique case (wr_addr)
                REG_IRQ_ENABLE_ONE: next_core.enable_one = wr_data[2:0];
                REG_IRQ_ENABLE_TWO: next_core.enable_two = wr_data[0];
                REG_ALARM_THRESHOLDS: {next_core.hot_threshold, next_core.cold_threshold} = wr_data;
                REG_THERMISTOR_CONFIG: begin
                    // RULE4 threshold field
                    next_core.change_field = wr_data[1:0];
                    if (wr_data[FLD_START] && !core.busy) begin
                        next_core.busy = 1'b1;
                        next_core.start = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
        if (!wake_hi) begin
            // wake low forgets baseline and flags
            next_core.base_valid = 1'b0;
            next_core.status_one = 3'h0;
            next_core.status_two = 1'b0;
        end
    end

    // core registers
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            // RULE8 change enable resets off
            core <= '{reading: 8'h00, baseline: 8'h00, base_valid: 1'b0, busy: 1'b0, start: 1'b0,
                      status_one: 3'h0, status_two: 1'b0, enable_one: IRQ_ENABLE_ONE_RST,
                      enable_two: IRQ_ENABLE_TWO_RST, change_field: CHANGE_FIELD_RST,
                      hot_threshold: HOT_THRESHOLD_RST, cold_threshold: COLD_THRESHOLD_RST};
        end else begin
            core <= next_core;
        end
    end

    assign conv_start = core.start;

    // ==========================================================
    // interrupt pin
    logic irq_q;

    // RULE21 enables gate only the pin
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(core.status_one & core.enable_one) | (core.status_two & core.enable_two);
        end
    end

    assign irq_out_n = ~irq_q;
    assign irq_oe = irq_q;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence s_cold_event;
        conv_done && is_cold && core.enable_one[FLD_COLD] && wake_hi && !clr_one;
    endsequence
    sequence s_addr_done;
        i2c.state == ST_ADDR && scl_fall && i2c.cnt == 4'h8 && i2c.sh[7:1] == SLAVE_ADDR && !bus_start && !bus_stop;
    endsequence

    property p_cold_irq;
        s_cold_event |=> core.status_one[FLD_COLD] ##1 !irq_out_n;
    endproperty
    a_cold_irq: assert property (p_cold_irq) else $error("cold event did not pull interrupt low"); // RULE5
    property p_hot_flag;
        conv_done && $signed(conv_data) >= taip_hot_deg(core.hot_threshold) && wake_hi
            |=> core.status_one[FLD_HOT];
    endproperty
    a_hot_flag: assert property (p_hot_flag) else $error("hot flag not set"); // RULE7
    property p_between;
        conv_done && !is_hot && !is_cold && core.status_one[2:1] == 2'h0 |=> core.status_one[2:1] == 2'h0;
    endproperty
    a_between: assert property (p_between) else $error("flag set for in-range reading"); // RULE6
    property p_baseline;
        conv_done && !core.base_valid && wake_hi |=> core.base_valid && core.baseline == $past(conv_data);
    endproperty
    a_baseline: assert property (p_baseline) else $error("first reading not taken as baseline"); // RULE2
    property p_change;
        conv_done && core.base_valid && wake_hi && taip_abs_diff(conv_data, core.baseline) >= {1'b0, change_thr}
            |=> core.status_one[FLD_CHANGE] && core.baseline == $past(conv_data);
    endproperty
    a_change: assert property (p_change) else $error("large change not flagged"); // RULE3
    property p_small;
        conv_done && core.base_valid && taip_abs_diff(conv_data, core.baseline) < {1'b0, change_thr}
            |=> $stable(core.baseline);
    endproperty
    a_small: assert property (p_small) else $error("baseline moved on small change"); // RULE3
    property p_change_masked;
        core.status_one == 3'h1 && !core.status_two && !core.enable_one[FLD_CHANGE] |=> irq_out_n;
    endproperty
    a_change_masked: assert property (p_change_masked) else $error("masked change drove interrupt"); // RULE8
    property p_addr_ack;
        s_addr_done |=> i2c.oe && i2c.state == ST_ACK;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("address not acknowledged"); // RULE17
    property p_ptr_inc;
        wr_en |=> i2c.ptr == $past(i2c.ptr) + 8'h01;
    endproperty
    a_ptr_inc: assert property (p_ptr_inc) else $error("pointer did not advance"); // RULE18
    property p_read_clear;
        clr_one && !conv_done && wake_hi |=> core.status_one == 3'h0 ##1 irq_q == $past(core.status_two & core.enable_two);
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("status read did not clear"); // RULE20
    property p_stop;
        bus_stop && !bus_start |=> i2c.state == ST_IDLE && !sda_oe;
    endproperty
    a_stop: assert property (p_stop) else $error("stop did not end transaction"); // RULE16

endmodule : taip_top
`default_nettype wire

// File: rtl/taip_pkg.sv
// Purpose: shared constants and types for the temperature alert block with its two-wire slave port
// Assumes: registers are 8 bits wide, reached only through the two-wire port
// Notes: temperatures are signed whole degrees
package taip_pkg;

    // ==========================================================
    // register offsets
    localparam logic [7:0] REG_TEMPERATURE_READOUT = 8'h00;
    localparam logic [7:0] REG_IRQ_ENABLE_ONE = 8'h05;
    localparam logic [7:0] REG_IRQ_ENABLE_TWO = 8'h06;
    localparam logic [7:0] REG_IRQ_STATUS_GROUP_ONE = 8'h07;
    localparam logic [7:0] REG_IRQ_STATUS_TWO = 8'h08;
    localparam logic [7:0] REG_THERMISTOR_CONFIG = 8'h0D;
    localparam logic [7:0] REG_ALARM_THRESHOLDS = 8'h0E;

    // ==========================================================
    // field positions
    localparam int FLD_CHANGE = 0;      // temp_change_flag in group one
    localparam int FLD_COLD = 1;        // cold flag in group one
    localparam int FLD_HOT = 2;         // hot flag in group one
    localparam int FLD_EOC = 0;         // end of conversion in group two
    localparam int FLD_START = 7;       // thermistor_config start bit
    localparam int FLD_IDLE = 5;        // conversion_idle_bit

    // ==========================================================
    // reset values
    localparam logic [2:0] IRQ_ENABLE_ONE_RST = 3'h6;   // hot and cold on, change off
    localparam logic IRQ_ENABLE_TWO_RST = 1'b1;
    localparam logic [1:0] CHANGE_FIELD_RST = 2'h0;     // two degrees
    localparam logic [3:0] HOT_THRESHOLD_RST = 4'h6;    // 48 degrees
    localparam logic [3:0] COLD_THRESHOLD_RST = 4'h0;   // 0 degrees
    localparam logic [7:0] CHANGE_BASE_DEG = 8'h02;     // change threshold at field zero

    // ==========================================================
    // state of the alert core
    typedef struct packed {
        logic [7:0] reading;
        logic [7:0] baseline;
        logic base_valid;
        logic busy;
        logic start;
        logic [2:0] status_one;
        logic status_two;
        logic [2:0] enable_one;
        logic enable_two;
        logic [1:0] change_field;
        logic [3:0] hot_threshold;
        logic [3:0] cold_threshold;
    } taip_core_t;

    typedef enum logic [6:0] {
        ST_IDLE = 7'b0000001,
        ST_ADDR = 7'b0000010,
        ST_ACK = 7'b0000100,
        ST_SUB = 7'b0001000,
        ST_WDATA = 7'b0010000,
        ST_RDATA = 7'b0100000,
        ST_RACK = 7'b1000000
    } taip_state_t;

    // state of the two-wire slave
    typedef struct packed {
        taip_state_t state;
        taip_state_t ack_to;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [7:0] tx;
        logic [7:0] ptr;
        logic mack;
        logic oe;
    } taip_i2c_t;

    // cold field is a signed degree count
    function automatic logic signed [7:0] taip_cold_deg(input logic [3:0] f);
        return $signed({{4{f[3]}}, f});
    endfunction : taip_cold_deg

    // hot field counts steps of eight degrees
    function automatic logic signed [7:0] taip_hot_deg(input logic [3:0] f);
        return $signed({1'b0, f, 3'b000});
    endfunction : taip_hot_deg

    // magnitude of reading minus baseline
    function automatic logic [8:0] taip_abs_diff(input logic [7:0] a, input logic [7:0] b);
        logic signed [8:0] d;
        d = $signed({a[7], a}) - $signed({b[7], b});
        return d[8] ? 9'(-d) : 9'(d);
    endfunction : taip_abs_diff

endpackage : taip_pkg

// File: tb/taip_host_model.sv
// Purpose: two-wire master model standing in for the host processor
// Assumes: pull-up on the data line, bit timing counted in clk_sys cycles
// Notes: scl rests high between frames, 8 cycles per bit
`timescale 1ns/1ps
`default_nettype none
module taip_host_model (
    input wire logic clk_sys,
    input wire logic dev_oe,
    input wire logic dev_out,
    output logic scl,
    output logic sda
);
    logic pull_low = 1'b0;

    // ==========================================================
    // wired-and data line with pull-up
    assign sda = ~(pull_low | (dev_oe & ~dev_out));
    initial scl = 1'b1;

    // data moves only while scl low
    task automatic clk_bit(input logic b, output logic r);
        scl <= 1'b0;
        repeat (2) @(posedge clk_sys);
        pull_low <= ~b;
        repeat (3) @(posedge clk_sys);
        scl <= 1'b1;
        repeat (3) @(posedge clk_sys);
        r = sda;
    endtask : clk_bit

    // start and stop are sda edges with scl high
    task automatic edge_cond(input logic stop);
        logic r;
        clk_bit(~stop, r);
        pull_low <= ~stop;
        repeat (3) @(posedge clk_sys);
    endtask : edge_cond

    // eight bits msb first, then the acknowledge slot
    task automatic xfer_byte(input logic [7:0] d, input logic mack, output logic [7:0] q, output logic ack_n);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(d[i], r);
            q[i] = r;
        end
        clk_bit(mack, ack_n);
    endtask : xfer_byte
endmodule : taip_host_model
`default_nettype wire

// File: tb/testbench.sv
// Purpose: self-checking bench for the temperature alert block
// Assumes: host model on the two-wire port, bench plays the converter
// Notes: every status read covers group one and group two together
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import taip_pkg::*;
    localparam logic [6:0] DEV_ADDR = 7'h2A;    // arbitrary value
    logic clk_sys;
    logic reset = 1'b1;
    logic wake_pin = 1'b1;
    logic conv_done = 1'b0;
    logic [7:0] conv_data = 8'h00;
    logic scl;
    logic sda;
    logic sda_oe;
    logic sda_out;
    logic conv_start;
    logic irq_out_n;
    logic irq_oe;
    int starts = 0;
    int error_cnt = 0;
    int comparisons = 0;

    // ==========================================================
    // clock, instances and conversion request counter
    initial clk_sys = 1'b0;
    always #20 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        if (conv_start === 1'b1) begin
            starts <= starts + 1;
        end
    end
    taip_top #(.SLAVE_ADDR(DEV_ADDR)) u_taip_top (.clk_sys(clk_sys), .reset(reset), .wake_pin(wake_pin),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .conv_done(conv_done),
        .conv_data(conv_data), .conv_start(conv_start), .irq_out_n(irq_out_n), .irq_oe(irq_oe));
    taip_host_model u_taip_host_model (.clk_sys(clk_sys), .dev_oe(sda_oe), .dev_out(sda_out),
        .scl(scl), .sda(sda));

    // ==========================================================
    // compare, verdict and bus tasks
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic results;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results

    // start, address, sub-address; read adds a repeated start
    task automatic head(input logic [7:0] sub, input logic rd, output logic nack);
        logic [7:0] q;
        logic a;
        u_taip_host_model.edge_cond(1'b0);
        u_taip_host_model.xfer_byte({DEV_ADDR, 1'b0}, 1'b1, q, nack);
        u_taip_host_model.xfer_byte(sub, 1'b1, q, a);
        nack |= a;
        if (rd) begin
            u_taip_host_model.edge_cond(1'b0);
            u_taip_host_model.xfer_byte({DEV_ADDR, 1'b1}, 1'b1, q, a);
            nack |= a;
        end
    endtask : head

    task automatic reg_write(input logic [7:0] sub, input int n, input logic [7:0] d0, input logic [7:0] d1);
        logic [7:0] q;
        logic a;
        logic nack;
        head(sub, 1'b0, nack);
        for (int i = 0; i < n; i++) begin
            u_taip_host_model.xfer_byte(i == 0 ? d0 : d1, 1'b1, q, a);
            nack |= a;
        end
        u_taip_host_model.edge_cond(1'b1);
        check("write ack", {7'h00, nack}, 8'h00);
    endtask : reg_write

    task automatic reg_read(input logic [7:0] sub, input int n, input logic [7:0] e0, input logic [7:0] e1);
        logic [7:0] q;
        logic a;
        logic nack;
        head(sub, 1'b1, nack);
        for (int i = 0; i < n; i++) begin
            u_taip_host_model.xfer_byte(8'hFF, i == n - 1, q, a);
            check("read data", q, i == 0 ? e0 : e1);
        end
        u_taip_host_model.edge_cond(1'b1);
        check("read ack", {7'h00, nack}, 8'h00);
    endtask : reg_read

    task automatic irq_is(input logic low);
        check("interrupt pins", {6'h00, irq_oe, irq_out_n}, {6'h00, low, ~low});
    endtask : irq_is

    // start a conversion and answer it with one reading
    task automatic acquire(input logic [7:0] cfg, input logic [7:0] t);
        int s0;
        int k;
        s0 = starts;
        reg_write(REG_THERMISTOR_CONFIG, 1, cfg, 8'h00);
        k = 0;
        while (starts == s0 && k < 200) begin
            @(posedge clk_sys);
            k++;
        end
        if (k == 200) begin
            error_cnt++;
            $display("wait for conversion request ran out");
            results();
        end
        conv_data <= t;
        conv_done <= 1'b1;
        @(posedge clk_sys);
        conv_done <= 1'b0;
        repeat (4) @(posedge clk_sys);
        check("request count", 8'(starts - s0), 8'h01);
    endtask : acquire

    // ==========================================================
    // main sequence
    initial begin
        logic [7:0] q;
        logic a;
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (5) @(posedge clk_sys);
        irq_is(1'b0);
        reg_read(REG_IRQ_ENABLE_ONE, 2, 8'h06, 8'h01);
        reg_read(REG_THERMISTOR_CONFIG, 2, 8'h20, 8'h60);
        reg_read(REG_IRQ_STATUS_GROUP_ONE, 2, 8'h00, 8'h00);
        acquire(8'h80, 8'h14);
        reg_read(REG_TEMPERATURE_READOUT, 1, 8'h14, 8'h00);
        reg_read(REG_IRQ_STATUS_GROUP_ONE, 2, 8'h00, 8'h01);
        reg_write(REG_IRQ_ENABLE_TWO, 1, 8'h00, 8'h00);
        acquire(8'h80, 8'h16);
        irq_is(1'b0);
        reg_read(REG_IRQ_STATUS_GROUP_ONE, 2, 8'h01, 8'h01);
        acquire(8'h80, 8'h17);
        reg_read(REG_IRQ_STATUS_GROUP_ONE, 2, 8'h00, 8'h01);
        acquire(8'h80, 8'h30);
        irq_is(1'b1);
        reg_read(REG_IRQ_STATUS_GROUP_ONE, 2, 8'h05, 8'h01);
        irq_is(1'b0);
        acquire(8'h80, 8'h30);
        reg_read(REG_IRQ_STATUS_GROUP_ONE, 2, 8'h04, 8'h01);
        reg_write(REG_IRQ_ENABLE_ONE, 1, 8'h02, 8'h00);
        acquire(8'h80, 8'h30);
        irq_is(1'b0);
        reg_read(REG_IRQ_STATUS_GROUP_ONE, 2, 8'h04, 8'h01);
        reg_write(REG_IRQ_ENABLE_ONE, 1, 8'h06, 8'h00);
        reg_read(REG_IRQ_ENABLE_ONE, 1, 8'h06, 8'h00);
        reg_write(REG_THERMISTOR_CONFIG, 2, 8'h01, 8'h7E);
        reg_read(REG_THERMISTOR_CONFIG, 2, 8'h21, 8'h7E);
        acquire(8'h81, 8'hFE);
        irq_is(1'b1);
        reg_read(REG_IRQ_STATUS_GROUP_ONE, 2, 8'h03, 8'h01);
        reg_write(REG_IRQ_ENABLE_ONE, 1, 8'h07, 8'h00);
        acquire(8'h81, 8'h01);
        irq_is(1'b1);
        reg_read(REG_IRQ_STATUS_GROUP_ONE, 2, 8'h01, 8'h01);
        acquire(8'h81, 8'h03);
        reg_read(REG_IRQ_STATUS_GROUP_ONE, 2, 8'h00, 8'h01);
        wake_pin <= 1'b0;
        repeat (6) @(posedge clk_sys);
        wake_pin <= 1'b1;
        repeat (6) @(posedge clk_sys);
        acquire(8'h81, 8'h20);
        reg_read(REG_IRQ_STATUS_GROUP_ONE, 2, 8'h00, 8'h01);
        acquire(8'h81, 8'h23);
        reg_read(REG_IRQ_STATUS_GROUP_ONE, 2, 8'h01, 8'h01);
        u_taip_host_model.edge_cond(1'b0);
        u_taip_host_model.xfer_byte({7'h15, 1'b0}, 1'b1, q, a);
        u_taip_host_model.edge_cond(1'b1);
        check("foreign address ack", {7'h00, a}, 8'h01);
        results();
    end
endmodule : testbench
`default_nettype wire
